// ### inc/pwdt_pkg.sv
// Shared constants and types for the protected watchdog timer.
package pwdt_pkg;

  // ----------------------------------------
  // Register map: word indices, byte address = 4 * index
  // ----------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CTL = 16'hffbe;
  localparam logic [15:0] IDX_CNT = 16'hffbf;
  localparam logic [15:0] IDX_ISTS = 16'hffb0;
  localparam logic [15:0] IDX_IEN = 16'hffb1;
  localparam logic [15:0] IDX_ICLR = 16'hffb2;

  // ----------------------------------------
  // Control/status field positions and reset values
  // ----------------------------------------
  localparam int BIT_FLAG = 0;
  localparam int BIT_FLAG_WI = 1;
  localparam int BIT_RUN = 2;
  localparam int BIT_RUN_WI = 3;
  localparam int BIT_CTLWE = 4;
  localparam int BIT_CTLWE_WI = 5;
  localparam int BIT_CWE = 6;
  localparam int BIT_CWE_WI = 7;
  localparam logic [7:0] CTL_RST = 8'haa;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ----------------------------------------
  // Interrupt event bits
  // ----------------------------------------
  localparam int EV_W = 2;
  localparam int EV_OVF = 0;
  localparam int EV_REL = 1;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int PRESC_DIV = 8192;
  localparam int IRESET_OSC_CYC = 512;
  localparam logic [8:0] OSC_LAST = 9'(IRESET_OSC_CYC - 1);

  // ----------------------------------------
  // Power modes and internal reset sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'h0, PM_SLEEP = 3'h1, PM_WATCH = 3'h2,
    PM_SUBACTIVE = 3'h3, PM_SUBSLEEP = 3'h4, PM_STANDBY = 3'h5
  } pwdt_mode_t;
  typedef enum logic [1:0] {ST_NORMAL = 2'h0, ST_IRESET = 2'h1} pwdt_state_t;

endpackage

// ### src/pwdt_top.sv
// Protected watchdog timer with APB register access and chip reset output.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// How it works
// - 8-bit counter advances per divide-by-8192 tick
// - Rollover FF to 00 requests reset, sets flag
// - Internal reset lasts exactly 512 oscillator cycles
// - Overflow reset goes chip-wide, clears watchdog except flag and interrupts
// - Counter write loads value, counting continues upward
// - Counter writes need counter write enable set
// - Odd inhibit bits read one, never store
// - Bit 6 changes only with bit 7 zero
// - Bit 4 changes only with bit 5 zero
// - Run bit needs enable plus inhibit zero
// - Run bit starts, stops counting; reset clears
// - Flag cleared by pin or guarded zero write
// - Reset gives counter 00 and control aa
// - Counting only in active and sleep modes
module pwdt_top
  import pwdt_pkg::*;
#(
  parameter int PRESC = PRESC_DIV
)
(
  // Clock and external reset pin.
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Chip context.
  input wire logic [2:0] pwr_mode,
  input wire logic oscillator_clock,
  // Outputs.
  output logic chip_reset,
  output logic irq
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Exact match of a byte address against a register word index.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [12:0] presc_r;
  logic [7:0] cnt_r;
  logic cwe_r;
  logic ctlwe_r;
  logic run_r;
  logic flag_r;
  pwdt_state_t state_r;
  logic [8:0] osc_cnt_r;
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_prev_r;
  logic chip_reset_r;
  logic [EV_W-1:0] ists_r;
  logic [EV_W-1:0] ien_r;
  logic irq_r;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------

  // The answer comes one cycle into the access phase so that pready is a flop.
  wire req = psel & penable & ~pready_r;
  wire acc = psel & penable & pready_r;
  wire wr = acc & pwrite;
  wire [7:0] d = pwdata[7:0];
  wire hit_ctl = hit(paddr, IDX_CTL);
  wire hit_cnt = hit(paddr, IDX_CNT);
  wire hit_ists = hit(paddr, IDX_ISTS);
  wire hit_ien = hit(paddr, IDX_IEN);
  wire hit_iclr = hit(paddr, IDX_ICLR);
  wire mapped = hit_ctl | hit_cnt | hit_ists | hit_ien | hit_iclr;
  wire wr_ctl = wr & hit_ctl;
  wire wr_cnt = wr & hit_cnt;
  wire wr_ien = wr & hit_ien;
  wire wr_iclr = wr & hit_iclr;

  // Inhibit companions are constant ones on read.
  wire [7:0] ctl_rd = {1'b1, cwe_r, 1'b1, ctlwe_r, 1'b1, run_r, 1'b1, flag_r};
  wire [31:0] rd_mux = hit_ctl ? {24'h000000, ctl_rd} :
                       hit_cnt ? {24'h000000, cnt_r} :
                       hit_ists ? {30'h00000000, ists_r} :
                       hit_ien ? {30'h00000000, ien_r} : 32'h00000000;

  // ----------------------------------------
  // Prescaler and count enable
  // ----------------------------------------
  wire in_ireset = state_r == ST_IRESET;
  wire tick = presc_r == 13'(PRESC - 1);
  wire [12:0] presc_nxt = (in_ireset | tick) ? 13'h0000 : presc_r + 13'h0001;
  wire mode_runs = (pwr_mode == PM_ACTIVE) | (pwr_mode == PM_SLEEP);
  wire cnt_en = tick & run_r & mode_runs;
  wire cnt_wr = wr_cnt & cwe_r;
  // A write in the same cycle as a tick wins, so a reload never overflows.
  wire ovf = cnt_en & ~cnt_wr & (cnt_r == CNT_MAX);

  // ----------------------------------------
  // Oscillator edge detect and reset sequencer
  // ----------------------------------------
  wire osc_rise = osc_s2_r & ~osc_prev_r;
  wire rel = in_ireset & osc_rise & (osc_cnt_r == OSC_LAST);
  wire [8:0] osc_cnt_nxt = !in_ireset ? 9'h000 : osc_rise ? osc_cnt_r + 9'h001 : osc_cnt_r;
  pwdt_state_t state_nxt;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL:
      begin
        if (ovf)
          state_nxt = ST_IRESET;
      end
      ST_IRESET:
      begin
        if (rel)
          state_nxt = ST_NORMAL;
      end
      default:
        state_nxt = ST_NORMAL;
    endcase
  end

  // ----------------------------------------
  // Protected register next values
  // ----------------------------------------

  // The internal reset clears the prescaler, counter and control bits except the flag, which records it.
  wire cwe_nxt = in_ireset ? 1'b0 : (wr_ctl & ~d[BIT_CWE_WI]) ? d[BIT_CWE] : cwe_r;
  wire ctlwe_nxt = in_ireset ? 1'b0 : (wr_ctl & ~d[BIT_CTLWE_WI]) ? d[BIT_CTLWE] : ctlwe_r;
  wire run_wr = wr_ctl & ctlwe_r & ~d[BIT_RUN_WI];
  wire run_nxt = in_ireset ? 1'b0 : run_wr ? d[BIT_RUN] : run_r;
  wire flag_clr = wr_ctl & ctlwe_r & ~d[BIT_FLAG_WI] & ~d[BIT_FLAG];
  wire flag_nxt = ovf ? 1'b1 : flag_clr ? 1'b0 : flag_r;
  wire [7:0] cnt_nxt = in_ireset ? CNT_RST : cnt_wr ? d : cnt_en ? cnt_r + 8'h01 : cnt_r;

  // ----------------------------------------
  // Interrupt next values
  // ----------------------------------------

  // A new event beats a clear written in the same cycle.
  wire [EV_W-1:0] ev = {rel, ovf};
  wire [EV_W-1:0] iclr = wr_iclr ? d[EV_W-1:0] : 2'b00;
  wire [EV_W-1:0] ists_nxt = ev | (ists_r & ~iclr);
  wire [EV_W-1:0] ien_nxt = wr_ien ? d[EV_W-1:0] : ien_r;

  // ----------------------------------------
  // Bus answer flops
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= req;
      prdata_r <= (req & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr_r <= req & ~mapped;
    end
  end

  // ----------------------------------------
  // Watchdog registers
  // ----------------------------------------

  // The external reset pin is the only thing that clears the flag outright.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      presc_r <= 13'h0000;
      cnt_r <= CNT_RST;
      cwe_r <= CTL_RST[BIT_CWE];
      ctlwe_r <= CTL_RST[BIT_CTLWE];
      run_r <= CTL_RST[BIT_RUN];
      flag_r <= CTL_RST[BIT_FLAG];
    end
    else
    begin
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
      cwe_r <= cwe_nxt;
      ctlwe_r <= ctlwe_nxt;
      run_r <= run_nxt;
      flag_r <= flag_nxt;
    end
  end

  // ----------------------------------------
  // Reset sequencer flops
  // ----------------------------------------

  // The oscillator input is resynchronised; only the second stage feeds the edge detect.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= ST_NORMAL;
      osc_cnt_r <= 9'h000;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_prev_r <= 1'b0;
      chip_reset_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      osc_s1_r <= oscillator_clock;
      osc_s2_r <= osc_s1_r;
      osc_prev_r <= osc_s2_r;
      chip_reset_r <= state_nxt == ST_IRESET;
    end
  end

  // ----------------------------------------
  // Interrupt flops
  // ----------------------------------------

  // These survive the internal reset so software can see why it restarted.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ists_r <= 2'b00;
      ien_r <= 2'b00;
      irq_r <= 1'b0;
    end
    else
    begin
      ists_r <= ists_nxt;
      ien_r <= ien_nxt;
      irq_r <= |(ists_nxt & ien_nxt);
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign chip_reset = chip_reset_r;
  assign irq = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  // Counts oscillator rises seen while the chip reset is out.
  logic [9:0] hlp_rises_r;
  always_ff @(posedge ref_clk)
  begin
    if (rst || !chip_reset_r)
      hlp_rises_r <= 10'h000;
    else
      hlp_rises_r <= hlp_rises_r + {9'h000, osc_rise};
  end

  cnt_advance_a: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_en && !cnt_wr && cnt_r != CNT_MAX && !in_ireset |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not advance on tick");

  ovf_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    ovf |=> flag_r && chip_reset_r && cnt_r == CNT_RST)
    else $error("overflow did not raise reset and flag");

  ireset_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(chip_reset_r) |-> hlp_rises_r == 10'(IRESET_OSC_CYC))
    else $error("internal reset length wrong");

  ireset_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    chip_reset_r |=> !run_r && !cwe_r && !ctlwe_r && cnt_r == CNT_RST)
    else $error("internal reset left block state");

  cnt_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_wr && !in_ireset |=> cnt_r == $past(pwdata[7:0]))
    else $error("counter write not loaded");

  cnt_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cnt && !cwe_r && !cnt_en && !in_ireset |=> $stable(cnt_r))
    else $error("locked counter changed");

  inhibit_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    req && !pwrite && hit_ctl |=> (prdata_r[7:0] & 8'haa) == 8'haa)
    else $error("inhibit bits not read as one");

  cwe_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl && d[BIT_CWE_WI] && !in_ireset |=> $stable(cwe_r))
    else $error("counter write enable changed while inhibited");

  ctlwe_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl && !ctlwe_r && !in_ireset && !ovf |=> $stable(run_r) && $stable(flag_r))
    else $error("protected bits changed without enable");

  run_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl && ctlwe_r && !d[BIT_RUN_WI] && !in_ireset |=> run_r == $past(d[BIT_RUN]))
    else $error("unlocked run write not taken");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    flag_clr && !ovf |=> !flag_r)
    else $error("flag not cleared");

  reset_vals_a: assert property (@(posedge ref_clk)
    rst |=> ctl_rd == CTL_RST && cnt_r == CNT_RST && !chip_reset_r)
    else $error("reset values wrong");

  mode_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
    !mode_runs && !wr_cnt && !in_ireset |=> $stable(cnt_r))
    else $error("counter moved in halted mode");

  ctlwe_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl && d[BIT_CTLWE_WI] && !in_ireset |=> $stable(ctlwe_r))
    else $error("control write enable changed while inhibited");

  run_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !run_r && !cnt_wr && !in_ireset |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  tick_space_a: assert property (@(posedge ref_clk) disable iff (rst || in_ireset)
    tick |=> !tick)
    else $error("prescaler tick wider than one cycle");

endmodule

// ### tb/pwdt_top_tb_top.sv
// Self-checking testbench for the protected watchdog timer.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module pwdt_top_tb_top
  import pwdt_pkg::*;
;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic ref_clk, rst, psel, penable, pwrite, oscillator_clock, pready, pslverr, chip_reset, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pwr_mode;
  logic [2:0] osc_div;
  int bad_count, total_checks;
  pwdt_top #(.PRESC(16)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pwr_mode(pwr_mode), .oscillator_clock(oscillator_clock),
    .chip_reset(chip_reset), .irq(irq));
  // Clock of 20 ns period.
  initial
  begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Oscillator runs at one eighth of the system clock, so one period outlasts the synchroniser delay.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_div <= 3'h0;
      oscillator_clock <= 1'b0;
    end
    else
    begin
      osc_div <= osc_div + 3'h1;
      oscillator_clock <= osc_div[2];
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Ready is sampled on the rising edge; the request stands until an edge sees it high, and no cycle count is assumed.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string nm);
    logic [31:0] r;
    rd(idx, r);
    `CHK(nm, 32'(exp), r)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_locks();
    logic [31:0] r;
    logic e;
    rdchk(IDX_CTL, 8'haa, "ctl");
    rdchk(IDX_CNT, 8'h00, "cnt");
    wr(IDX_CNT, 8'h55);
    rdchk(IDX_CNT, 8'h00, "cnt locked");
    wr(IDX_CTL, 8'h40);
    rdchk(IDX_CTL, 8'hea, "cwe set");
    wr(IDX_CTL, 8'h80);
    rdchk(IDX_CTL, 8'hea, "cwe kept");
    wr(IDX_CTL, 8'he4);
    rdchk(IDX_CTL, 8'hea, "run blocked");
    wr(IDX_CNT, 8'hf0);
    rdchk(IDX_CNT, 8'hf0, "cnt load");
    wr(IDX_CTL, 8'h9a);
    rdchk(IDX_CTL, 8'hfa, "ctlwe set");
    apb(1'b0, 16'hff00, 8'h00, r, e);
    `CHK("unmapped err", 1'b1, e)
  endtask
  // Samples of the counter lie exactly 48 cycles apart, which is three prescaler ticks.
  task automatic t_modes();
    logic [31:0] a, b;
    wr(IDX_CNT, 8'h00);
    wr(IDX_CTL, 8'ha6);
    rdchk(IDX_CTL, 8'hfe, "run on");
    for (int m = 0; m < 6; m++)
    begin
      pwr_mode <= 3'(m);
      rd(IDX_CNT, a);
      repeat (44) @(posedge ref_clk);
      rd(IDX_CNT, b);
      `CHK("ticks", (m < 2) ? 32'h3 : 32'h0, b - a)
    end
    pwr_mode <= 3'h0;
    wr(IDX_CTL, 8'ha2);
    rd(IDX_CNT, a);
    repeat (44) @(posedge ref_clk);
    rd(IDX_CNT, b);
    `CHK("stopped", a, b)
  endtask
  task automatic t_overflow();
    int n;
    wr(IDX_IEN, 8'h01);
    wr(IDX_CTL, 8'h9a);
    wr(IDX_CTL, 8'ha6);
    wr(IDX_CNT, 8'hfe);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (chip_reset !== 1'b1 && n < 100);
    `CHK("two ticks", 1'b1, n >= 14 && n <= 36)
    n = 0;
    repeat (2) @(negedge ref_clk);
    `CHK("irq", 1'b1, irq)
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (chip_reset === 1'b1 && n < 6000);
    `CHK("reset len", 1'b1, n >= 4078 && n <= 4100)
    rdchk(IDX_CTL, 8'hab, "flag");
    rdchk(IDX_CNT, 8'h00, "cnt cleared");
    rdchk(IDX_ISTS, 8'h03, "status");
    wr(IDX_IEN, 8'h00);
    @(negedge ref_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(IDX_ICLR, 8'h03);
    rdchk(IDX_ISTS, 8'h00, "status clr");
  endtask
  task automatic t_flag_clear();
    wr(IDX_CTL, 8'ha8);
    rdchk(IDX_CTL, 8'hab, "flag kept");
    wr(IDX_CTL, 8'h9b);
    wr(IDX_CTL, 8'ha8);
    rdchk(IDX_CTL, 8'hba, "flag clr");
  endtask
  // A pin reset in the middle of an internal reset must end it and clear the flag.
  task automatic t_pin_reset();
    int n;
    wr(IDX_CTL, 8'h5e);
    wr(IDX_CTL, 8'ha6);
    wr(IDX_CNT, 8'hff);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (chip_reset !== 1'b1 && n < 40);
    `CHK("one tick", 1'b1, chip_reset)
    rdchk(IDX_CTL, 8'hab, "flag set");
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("reset ends", 1'b0, chip_reset)
    rdchk(IDX_CTL, 8'haa, "flag pin clr");
    rdchk(IDX_CNT, 8'h00, "cnt pin clr");
  endtask
  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The whole run needs about 4700 cycles; five times that means a hang.
  initial
  begin
    repeat (25000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
  // Reset for five cycles, then the scenarios in turn.
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pwr_mode = 3'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_and_locks();
    t_modes();
    t_overflow();
    t_flag_clear();
    t_pin_reset();
    test_done();
  end
endmodule
